/* File: core/sdmr_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit mode register data, 6-bit mode register address
// Notes: Definitions only
`ifndef SDMR_DEFINES_SVH
`define SDMR_DEFINES_SVH
`define SDMR_ADDR_IO_CFG 6'h03
`define SDMR_ADDR_TEMP 6'h04
`define SDMR_ADDR_LAT 6'h02
`define SDMR_ADDR_FSP 6'h0D
`define SDMR_IO_PUCAL 0
`define SDMR_IO_WPST 1
`define SDMR_IO_PROT 2
`define SDMR_IO_PULLDOWN_DRIVE_STRENGTH_LO 3
`define SDMR_IO_DBIRD 6
`define SDMR_IO_DBIWR 7
`define SDMR_IO_RESET 8'h31
`define SDMR_TMP_SRABORT 3
`define SDMR_TMP_REPAIR 4
`define SDMR_TMP_OFS_LO 5
`define SDMR_TMP_FLAG 7
`define SDMR_TMP_WMASK 8'h78
`define SDMR_RATE_1X 3'h3
`define SDMR_LAT_WLS 6
`define SDMR_WRITE_SET_POINT_SELECT 6
`define SDMR_OPERATING_SET_POINT_SELECT 7
`define SDMR_BL32_EXTRA 8'h08
`define SDMR_INIT_CYCLES 8'h10
`endif

/* File: core/sdmr_pkg.sv */
// Purpose: Types shared by both ends
// Assumes: Nothing
// Notes: Commands on the link
`default_nettype none
package sdmr_pkg;
  typedef enum logic [1:0] {
    SDMR_CMD_NONE = 2'b00,
    SDMR_CMD_WRITE = 2'b01,
    SDMR_CMD_READ = 2'b10
  } sdmr_cmd_type;
  typedef enum logic [1:0] {
    SDMR_ST_IDLE = 2'b00,
    SDMR_ST_WAIT = 2'b01,
    SDMR_ST_DONE = 2'b10
  } sdmr_state_type;
endpackage : sdmr_pkg
`default_nettype wire

/* File: core/sdmr_link_if.sv */
// Purpose: Mode register command link between controller and device
// Assumes: Same clock at both ends
// Notes: Read data one cycle after read command
`default_nettype none
interface sdmr_link_if;
  import sdmr_pkg::*;
  sdmr_cmd_type cmd;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport ctrl (output cmd, output addr, output wdata, input rdata, input rvalid);
  modport dev (input cmd, input addr, input wdata, output rdata, output rvalid);
endinterface : sdmr_link_if
`default_nettype wire

/* File: core/sdmr_precharge_timer.sv */
// Purpose: Delay from end of an auto-precharge burst to internal precharge
// Assumes: Start is a one-cycle pulse
// Notes: A new start restarts the count
`default_nettype none
module sdmr_precharge_timer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] count_i,
  output logic fire_o
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      fire_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (start_i) begin
        cnt_reg <= count_i;
        busy_reg <= (count_i != 8'h00);
        fire_o <= (count_i == 8'h00);
      end else if (busy_reg) begin
        if (cnt_reg == 8'h01) begin
          busy_reg <= 1'b0;
          fire_o <= 1'b1;
        end
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : sdmr_precharge_timer
`default_nettype wire

/* File: core/sdmr_device.sv */
// Purpose: Device end: I/O configuration and temperature mode registers
// Assumes: Controller keeps the link rules; sensor code from a core input
// Notes: Read data is registered, valid one cycle after the read command
// Rules from the document
// - Controller keeps clock within latency frequency limits; this controller leaves it to software
// - Read inversion bit selects longer read latency; this block only drives it out on read_bus_inversion_en_o
// - Write latency set bit picks set A/B
// - Read auto precharge waits programmed clock count
// - Write auto precharge waits write recovery clocks
// - Burst length 32 adds eight read clocks
// - Postamble bit: half or one-and-half clock
// - Controller programs calibration bit same both channels
// - Writes and reads reach write set point
// - Operation uses operating set point copy only
// - Repair protection is sticky until power-on reset
// - Protection refuses setting repair entry bit
// - Repair entry bit enters/exits repair, resets zero
// - Refresh rate field reports eight defined codes
// - Multiplier scales refresh intervals; top bit hot
// - Derating needed reports code 110b
// - Controller treats 000b, 111b as out-of-range
// - Rate change sets flag; read clears it
// - Flag zero at power-up; rate valid after init
// - Temperature write stores bits six to three
// - Thermal offset encodes none, 5, 10, reserved
//
// The plain strobed port is this design's own decision.
`default_nettype none
`include "sdmr_defines.svh"
module sdmr_device import sdmr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  sdmr_link_if.dev link,
  input wire logic [2:0] sensor_rate_i,
  input wire logic init_done_i,
  input wire logic bl32_i,
  input wire logic [7:0] read_to_precharge_clocks_i,
  input wire logic [7:0] write_recovery_clocks_i,
  input wire logic rd_ap_done_i,
  input wire logic wr_ap_done_i,
  output logic pullup_calib_point_o,
  output logic write_postamble_len_o,
  output logic repair_protect_o,
  output logic [2:0] pulldown_drive_strength_o,
  output logic read_bus_inversion_en_o,
  output logic write_bus_inversion_en_o,
  output logic write_latency_set_b_o,
  output logic repair_entry_o,
  output logic self_refresh_abort_ctl_o,
  output logic [1:0] thermal_offset_o,
  output logic precharge_o
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] io_cfg_reg [2];
  logic [7:0] temp_reg;
  logic [1:0] fsp_reg;
  logic wls_reg;
  logic protect_reg;
  logic [2:0] rate_reg;
  logic [7:0] init_cnt_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic is_wr;
  logic is_rd;
  logic [7:0] io_act;
  logic [7:0] rd_count;
  logic rd_fire;
  logic wr_fire;
  logic [7:0] temp_wr;
  assign is_wr = (link.cmd == SDMR_CMD_WRITE);
  assign is_rd = (link.cmd == SDMR_CMD_READ);
  // Operating copy drives the I/O outputs except repair_protect_o; the other may be rewritten freely
  assign io_act = io_cfg_reg[fsp_reg[1]];
  // Bits outside 6:3 dropped here, so a stray flag or rate bit cannot land
  assign temp_wr = link.wdata & `SDMR_TMP_WMASK;

  // ----------------------------------------
  // Set-point duplicated I/O configuration
  // ----------------------------------------
  // Each copy listens only while its set point is selected for writing
  generate
    for (genvar sp = 0; sp < 2; sp++) begin : g_sp
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          io_cfg_reg[sp] <= `SDMR_IO_RESET;
        end else if (is_wr && link.addr == `SDMR_ADDR_IO_CFG && fsp_reg[0] == 1'(sp)) begin
          io_cfg_reg[sp] <= link.wdata;
        end
      end
    end
  endgenerate

  // Protection copy kept outside the set points; only reset clears it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      protect_reg <= 1'b0;
    end else if (is_wr && link.addr == `SDMR_ADDR_IO_CFG && link.wdata[`SDMR_IO_PROT]) begin
      protect_reg <= 1'b1;
    end
  end

  // Latency set bit is a single register, not duplicated per set point
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fsp_reg <= 2'b00;
      wls_reg <= 1'b0;
    end else if (is_wr && link.addr == `SDMR_ADDR_FSP) begin
      fsp_reg <= {link.wdata[`SDMR_OPERATING_SET_POINT_SELECT], link.wdata[`SDMR_WRITE_SET_POINT_SELECT]};
    end else if (is_wr && link.addr == `SDMR_ADDR_LAT) begin
      wls_reg <= link.wdata[`SDMR_LAT_WLS];
    end
  end

  // ----------------------------------------
  // Temperature register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      init_cnt_reg <= 8'h00;
      rate_reg <= `SDMR_RATE_1X;
    end else if (init_cnt_reg != `SDMR_INIT_CYCLES) begin
      // Sensor ignored until init finishes, so early noise cannot set the flag
      if (init_done_i) begin
        init_cnt_reg <= init_cnt_reg + 8'h01;
      end
    end else begin
      rate_reg <= sensor_rate_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      temp_reg <= 8'h00;
    end else begin
      if (is_wr && link.addr == `SDMR_ADDR_TEMP) begin
        temp_reg[6:3] <= temp_wr[6:3];
        if (protect_reg && link.wdata[`SDMR_TMP_REPAIR]) begin
          temp_reg[`SDMR_TMP_REPAIR] <= temp_reg[`SDMR_TMP_REPAIR];
        end
      end
      // Set wins over the clear by read
      if (init_cnt_reg == `SDMR_INIT_CYCLES && sensor_rate_i != rate_reg) begin
        temp_reg[`SDMR_TMP_FLAG] <= 1'b1;
      end else if (is_rd && link.addr == `SDMR_ADDR_TEMP) begin
        temp_reg[`SDMR_TMP_FLAG] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= is_rd;
      if (is_rd) begin
        // Reads see the write set point, so a copy can be checked before switching
        case (link.addr)
          `SDMR_ADDR_IO_CFG: rdata_reg <= io_cfg_reg[fsp_reg[0]];
          `SDMR_ADDR_TEMP: rdata_reg <= {temp_reg[7:3], rate_reg};
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end
  assign link.rdata = rdata_reg;
  assign link.rvalid = rvalid_reg;

  // ----------------------------------------
  // Operating outputs and auto precharge
  // ----------------------------------------
  assign pullup_calib_point_o = io_act[`SDMR_IO_PUCAL];
  assign write_postamble_len_o = io_act[`SDMR_IO_WPST];
  assign repair_protect_o = protect_reg;
  assign pulldown_drive_strength_o = io_act[`SDMR_IO_PULLDOWN_DRIVE_STRENGTH_LO +: 3];
  assign read_bus_inversion_en_o = io_act[`SDMR_IO_DBIRD];
  assign write_bus_inversion_en_o = io_act[`SDMR_IO_DBIWR];
  assign write_latency_set_b_o = wls_reg;
  assign repair_entry_o = temp_reg[`SDMR_TMP_REPAIR];
  assign self_refresh_abort_ctl_o = temp_reg[`SDMR_TMP_SRABORT];
  assign thermal_offset_o = temp_reg[`SDMR_TMP_OFS_LO +: 2];
  // Limitation: a count plus the burst-32 extra above 255 wraps around
  assign rd_count = bl32_i ? read_to_precharge_clocks_i + `SDMR_BL32_EXTRA
                           : read_to_precharge_clocks_i;

  sdmr_precharge_timer u_rd_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(rd_ap_done_i),
    .count_i(rd_count),
    .fire_o(rd_fire)
  );
  sdmr_precharge_timer u_wr_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(wr_ap_done_i),
    .count_i(write_recovery_clocks_i),
    .fire_o(wr_fire)
  );
  // One shared pulse: a read and a write firing together give one precharge
  assign precharge_o = rd_fire | wr_fire;
endmodule : sdmr_device
`default_nettype wire

/* File: core/sdmr_controller.sv */
// Purpose: Controller end: issues mode register commands from a register port
// Assumes: One command outstanding; software keeps clock limits
// Notes: Regs 0 addr, 1 wdata, 2 go (bit0 read), 3 status
`default_nettype none
`include "sdmr_defines.svh"
module sdmr_controller import sdmr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  sdmr_link_if.ctrl link,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic out_of_range_o
);
  logic [5:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] result_reg;
  logic busy_reg;
  sdmr_cmd_type cmd_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      addr_reg <= 6'h00;
      wdata_reg <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == 2'h0) begin
      addr_reg <= reg_wdata_i[5:0];
    end else if (reg_wr_i && reg_addr_i == 2'h1) begin
      wdata_reg <= reg_wdata_i;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmd_reg <= SDMR_CMD_NONE;
      busy_reg <= 1'b0;
    end else begin
      // Clock rate against the latency limits is left to software
      cmd_reg <= SDMR_CMD_NONE;
      if (link.rvalid) begin
        busy_reg <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == 2'h2 && !busy_reg) begin
        cmd_reg <= reg_wdata_i[0] ? SDMR_CMD_READ : SDMR_CMD_WRITE;
        busy_reg <= reg_wdata_i[0];
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_reg <= 8'h00;
      out_of_range_o <= 1'b0;
    end else if (link.rvalid) begin
      result_reg <= link.rdata;
      if (addr_reg == `SDMR_ADDR_TEMP) begin
        out_of_range_o <= (link.rdata[2:0] == 3'h0) || (link.rdata[2:0] == 3'h7);
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= (reg_addr_i == 2'h3) ? {6'h00, out_of_range_o, busy_reg} : result_reg;
    end
  end
  assign link.cmd = cmd_reg;
  assign link.addr = addr_reg;
  assign link.wdata = wdata_reg;
endmodule : sdmr_controller
`default_nettype wire

/* File: sim/sdmr_link_chk.sv */
// Purpose: Link checker for mode register traffic
// Assumes: Link signals seen as plain inputs
// Notes: Shadow tracks stored temperature bits
`default_nettype none
module sdmr_link_chk import sdmr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input var sdmr_cmd_type cmd,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // ----------------
  // Shadow state
  // ----------------
  logic prot_reg;
  logic [3:0] tmp_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prot_reg <= 1'b0;
    end else if (cmd == SDMR_CMD_WRITE && addr == 6'h03 && wdata[2]) begin
      prot_reg <= 1'b1;
    end
  end
  // Repair bit may always be cleared, only its setting is refused
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tmp_reg <= 4'h0;
    end else if (cmd == SDMR_CMD_WRITE && addr == 6'h04) begin
      tmp_reg <= {wdata[6:5], wdata[4] & (~prot_reg | tmp_reg[1]), wdata[3]};
    end
  end
  // ----------------
  // Link checks
  // ----------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd; cmd == SDMR_CMD_READ; endsequence
  sequence s_ans; rvalid; endsequence
  property p_rd_ans; s_rd |=> s_ans; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_ans_cause; rvalid |-> $past(cmd) == SDMR_CMD_READ; endproperty
  a_ans_cause: assert property (p_ans_cause) else $error("answer without read");
  property p_ans_pulse; s_ans |=> !rvalid; endproperty
  a_ans_pulse: assert property (p_ans_pulse) else $error("answer too long");
  property p_cmd_once; cmd != SDMR_CMD_NONE |=> cmd == SDMR_CMD_NONE; endproperty
  a_cmd_once: assert property (p_cmd_once) else $error("command too long");
  property p_cmd_legal; cmd inside {SDMR_CMD_NONE, SDMR_CMD_WRITE, SDMR_CMD_READ}; endproperty
  a_cmd_legal: assert property (p_cmd_legal) else $error("bad command");
  property p_unmapped; (s_rd ##0 addr == 6'h05) |=> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_temp_rd; (s_rd ##0 addr == 6'h04) |=> rdata[6:3] == tmp_reg; endproperty
  a_temp_rd: assert property (p_temp_rd) else $error("temp bits wrong");
  property p_addr_hold; rvalid |-> $stable(addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
endmodule : sdmr_link_chk
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Bench for controller and device joined by the link
// Assumes: Controller finishes a command within six cycles
// Notes: Device outputs, link data and flags compared
`default_nettype none
module tb_top import sdmr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [2:0] sensor_rate_i = 3'h3;
  logic bl32_i = 1'b0;
  logic rd_ap_i = 1'b0;
  logic wr_ap_i = 1'b0;
  logic init_done_i = 1'b1;
  logic [7:0] rtp_v = 8'h08;
  logic [7:0] nwr_v = 8'h06;
  wire logic [7:0] io_w;
  wire logic [3:0] tmp_w;
  logic [7:0] q;
  logic [7:0] st;
  logic [7:0] rdo_w;
  logic wls_w;
  logic pre_w;
  logic oor_w;
  int n_errors = 0;
  int check_count = 0;
  sdmr_link_if sdmr_link_if_inst ();
  sdmr_device sdmr_device_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link(sdmr_link_if_inst), .sensor_rate_i(sensor_rate_i), .init_done_i(init_done_i),
    .bl32_i(bl32_i), .read_to_precharge_clocks_i(rtp_v), .write_recovery_clocks_i(nwr_v),
    .rd_ap_done_i(rd_ap_i), .wr_ap_done_i(wr_ap_i), .pullup_calib_point_o(io_w[0]),
    .write_postamble_len_o(io_w[1]), .repair_protect_o(io_w[2]),
    .pulldown_drive_strength_o(io_w[5:3]), .read_bus_inversion_en_o(io_w[6]),
    .write_bus_inversion_en_o(io_w[7]), .write_latency_set_b_o(wls_w),
    .repair_entry_o(tmp_w[1]), .self_refresh_abort_ctl_o(tmp_w[0]),
    .thermal_offset_o(tmp_w[3:2]), .precharge_o(pre_w));
  sdmr_controller sdmr_controller_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link(sdmr_link_if_inst), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdo_w), .out_of_range_o(oor_w));
  sdmr_link_chk sdmr_link_chk_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .cmd(sdmr_link_if_inst.cmd), .addr(sdmr_link_if_inst.addr),
    .wdata(sdmr_link_if_inst.wdata), .rdata(sdmr_link_if_inst.rdata),
    .rvalid(sdmr_link_if_inst.rvalid));
  // ----------------
  // Helpers
  // ----------------
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rw(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : rw
  // Register read: data stand from the cycle after the strobe until the next read strobe
  task automatic rr(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = rdo_w;
    @(posedge sys_clk_i);
  endtask : rr
  // One mode register command; status read keeps the read strobe exercised
  task automatic mr(input logic rd, input logic [5:0] a, input logic [7:0] d);
    rw(2'h0, {2'h0, a});
    rw(2'h1, d);
    rw(2'h2, {7'h00, rd});
    q = 8'hXX;
    repeat (6) begin
      @(posedge sys_clk_i);
      if (sdmr_link_if_inst.rvalid === 1'b1) q = sdmr_link_if_inst.rdata;
    end
    rr(2'h3, st);
    chk({7'h00, st[0]}, 8'h00);
  endtask : mr
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_io;
    chk(io_w, 8'h31);
    mr(1'b0, 6'h03, 8'hCA);
    chk(io_w, 8'hCA);
    mr(1'b0, 6'h02, 8'h40);
    chk({7'h00, wls_w}, 8'h01);
    mr(1'b0, 6'h02, 8'h00);
    chk({7'h00, wls_w}, 8'h00);
    mr(1'b0, 6'h0D, 8'h40);
    mr(1'b0, 6'h03, 8'h08);
    chk(io_w, 8'hCA);
    mr(1'b1, 6'h03, 8'h00);
    chk(q, 8'h08);
    mr(1'b0, 6'h0D, 8'hC0);
    chk(io_w, 8'h08);
    mr(1'b0, 6'h0D, 8'h00);
    chk(io_w, 8'hCA);
    mr(1'b1, 6'h05, 8'h00);
    chk(q, 8'h00);
    $display("io test done");
  endtask : t_io
  task automatic t_temp;
    mr(1'b0, 6'h04, 8'hFF);
    chk({4'h0, tmp_w}, 8'h0F);
    mr(1'b1, 6'h04, 8'h00);
    chk(q, 8'h7B);
    mr(1'b0, 6'h04, 8'h00);
    chk({4'h0, tmp_w}, 8'h00);
    mr(1'b0, 6'h03, 8'h0C);
    mr(1'b0, 6'h04, 8'h10);
    chk({4'h0, tmp_w}, 8'h00);
    mr(1'b0, 6'h03, 8'h08);
    chk(io_w, 8'h0C);
    $display("temp test done");
  endtask : t_temp
  task automatic t_rate;
    for (int k = 0; k < 8; k++) begin
      sensor_rate_i <= k[2:0];
      mr(1'b1, 6'h04, 8'h00);
      chk(q, {5'h10, k[2:0]});
      chk({7'h00, oor_w}, {7'h00, k == 0 || k == 7});
      chk({7'h00, st[1]}, {7'h00, k == 0 || k == 7});
      rr(2'h0, st);
      chk(st, {5'h10, k[2:0]});
    end
    mr(1'b1, 6'h04, 8'h00);
    chk(q, 8'h07);
    $display("rate test done");
  endtask : t_rate
  task automatic t_pre;
    int n;
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk_i);
      bl32_i <= (k == 1);
      rd_ap_i <= (k != 2);
      wr_ap_i <= (k == 2);
      @(posedge sys_clk_i);
      rd_ap_i <= 1'b0;
      wr_ap_i <= 1'b0;
      n = 0;
      while (pre_w !== 1'b1 && n < 40) begin
        @(posedge sys_clk_i);
        n++;
      end
      chk(n[7:0], (k == 0) ? 8'h09 : (k == 1) ? 8'h11 : 8'h07);
    end
    $display("precharge test done");
  endtask : t_pre
  // Mid-run reset: sticky protection and flag must come back cleared
  task automatic t_reset;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk(io_w, 8'h31);
    mr(1'b1, 6'h04, 8'h00);
    chk(q, 8'h03);
    $display("reset test done");
  endtask : t_reset
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_io;
    t_temp;
    t_rate;
    t_pre;
    t_reset;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
